// ===== hw/tfs_pkg.sv
// package of constants and types for the timer flag skip logic
package tfs_pkg;

    // ----------------------------------------------------------------
    // instruction codes (10-bit program words)
    // ----------------------------------------------------------------
    localparam int unsigned OP_W = 10;
    localparam logic [9:0] OP_SKIP_T1 = 10'h280;
    localparam logic [9:0] OP_SKIP_T2 = 10'h281;
    localparam logic [9:0] OP_SKIP_T3 = 10'h282;
    localparam logic [9:0] OP_SKIP_T4 = 10'h283;

    // ----------------------------------------------------------------
    // interrupt enable positions inside the control registers
    // ----------------------------------------------------------------
    localparam int unsigned CTRL_W = 4;
    localparam int unsigned T1_IRQ_EN_BIT = 2;
    localparam int unsigned T2_IRQ_EN_BIT = 3;
    localparam int unsigned T3_IRQ_EN_BIT = 0;
    localparam int unsigned T4_IRQ_EN_BIT = 1;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL1 = 8'h00;
    localparam logic [7:0] OFS_CTRL2 = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFS_LAST = 8'h14;
    localparam logic [7:0] OFS_SKIP_CNT = 8'h18;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [7:0] IRQ_RST = 8'h00;
    localparam logic [15:0] SKIP_CNT_RST = 16'h0000;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [9:0] opcode;
    } tfs_instr_t;

    typedef struct packed {
        logic hit;
        logic nop;
        logic skip;
        logic [3:0] clear;
        logic [1:0] timer;
    } tfs_result_t;

endpackage

// ===== hw/tfs_skip_eval.sv
// decode and skip decision for the four timer skip instructions
`timescale 1ns/1ps
module tfs_skip_eval
(
    // instruction in
    input wire tfs_pkg::tfs_instr_t instr,
    // flag state
    input wire logic [3:0] req_flags,
    input wire logic [3:0] irq_en,
    // decision out
    output tfs_pkg::tfs_result_t result
);

    function automatic logic [2:0] decode(input logic [9:0] op);
        case (op)
            tfs_pkg::OP_SKIP_T1: decode = 3'h4;
            tfs_pkg::OP_SKIP_T2: decode = 3'h5;
            tfs_pkg::OP_SKIP_T3: decode = 3'h6;
            tfs_pkg::OP_SKIP_T4: decode = 3'h7;
            default: decode = 3'h0;
        endcase
    endfunction

    logic [2:0] dec;
    logic taken;

    always_comb
    begin
        dec = decode(instr.opcode);
        result = '0;
        result.hit = instr.valid & dec[2];
        result.timer = dec[1:0];
        // enabled interrupt turns the instruction into a nop
        result.nop = result.hit & irq_en[dec[1:0]];
        // skip only on a set flag with the interrupt disabled
        taken = result.hit & ~irq_en[dec[1:0]] & req_flags[dec[1:0]];
        // flag at zero falls through to the next instruction
        result.skip = taken;
        result.clear = taken ? (4'h1 << dec[1:0]) : 4'h0;
    end

endmodule // tfs_skip_eval

// ===== hw/tfs_irq_status.sv
// sticky event status with mask and write-one-to-clear
`timescale 1ns/1ps
module tfs_irq_status
#(
    parameter int unsigned W = 8
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // events and software access
    input wire logic [W-1:0] events,
    input wire logic [W-1:0] clr,
    input wire logic [W-1:0] mask_d,
    input wire logic mask_we,
    // state out
    output logic [W-1:0] stat_q,
    output logic [W-1:0] mask_q,
    output logic irq
);

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stat_q <= W'(tfs_pkg::IRQ_RST);
        else
            stat_q <= (stat_q & ~clr) | events;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_q <= W'(tfs_pkg::IRQ_RST);
        else if (mask_we)
            mask_q <= mask_d;
    end

    assign irq = |(stat_q & mask_q);

endmodule // tfs_irq_status

// ===== hw/tfs_top.sv
// timer flag skip logic: apb registers, request flags and skip execution
//
// Contract
// - timer one, enable clear and flag set: skip next, then clear flag
// - timer one enable is bit 2 of first control register; set means nop
// - timer two, enable clear and flag set: skip next, then clear flag
// - timer two enable is bit 3 of first control register; set means nop
// - timer three, enable clear and flag set: skip next, clear flag
// - timer three enable is bit 0 of second control register; set means nop
// - timer four, enable clear and flag set: skip next, clear flag
// - timer four enable is bit 1 of second control register; set means nop
// - flag at zero: no skip, next instruction runs normally
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module tfs_top
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // instruction from the decoder
    input wire logic instr_valid,
    input wire logic [9:0] instr_opcode,
    // timer request events, one-cycle pulses
    input wire logic [3:0] timer_event,
    // to program counter sequencing
    output logic skip_next_q,
    output logic instr_done_q,
    // state out
    output logic [3:0] request_flags_q,
    output logic irq
);

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    logic wr_en;
    logic rd_en;
    logic addr_ok;

    function automatic logic mapped(input logic [7:0] a);
        case (a)
            tfs_pkg::OFS_CTRL1, tfs_pkg::OFS_CTRL2, tfs_pkg::OFS_FLAGS,
            tfs_pkg::OFS_IRQ_STAT, tfs_pkg::OFS_IRQ_MASK, tfs_pkg::OFS_LAST,
            tfs_pkg::OFS_SKIP_CNT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign addr_ok = mapped(paddr);
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_en = psel & penable & pwrite & addr_ok;
    assign rd_en = psel & penable & ~pwrite;

    // ----------------------------------------------------------------
    // interrupt control registers
    // ----------------------------------------------------------------
    logic [3:0] first_interrupt_control_register_q;
    logic [3:0] second_interrupt_control_register_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            first_interrupt_control_register_q <= tfs_pkg::CTRL_RST;
        else if (wr_en && paddr == tfs_pkg::OFS_CTRL1)
            first_interrupt_control_register_q <= pwdata[3:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            second_interrupt_control_register_q <= tfs_pkg::CTRL_RST;
        else if (wr_en && paddr == tfs_pkg::OFS_CTRL2)
            second_interrupt_control_register_q <= pwdata[3:0];
    end

    logic timer_one_irq_enable;
    logic timer_two_irq_enable;
    logic timer_three_irq_enable;
    logic timer_four_irq_enable;

    // enable bit positions
    assign timer_one_irq_enable = first_interrupt_control_register_q[tfs_pkg::T1_IRQ_EN_BIT];
    assign timer_two_irq_enable = first_interrupt_control_register_q[tfs_pkg::T2_IRQ_EN_BIT];
    assign timer_three_irq_enable =
        second_interrupt_control_register_q[tfs_pkg::T3_IRQ_EN_BIT];
    assign timer_four_irq_enable =
        second_interrupt_control_register_q[tfs_pkg::T4_IRQ_EN_BIT];

    // ----------------------------------------------------------------
    // skip decision
    // ----------------------------------------------------------------
    tfs_pkg::tfs_instr_t instr;
    tfs_pkg::tfs_result_t res;

    assign instr.valid = instr_valid;
    assign instr.opcode = instr_opcode;

    tfs_skip_eval u_eval
    (
        .instr(instr),
        .req_flags(request_flags_q),
        .irq_en({timer_four_irq_enable, timer_three_irq_enable,
                 timer_two_irq_enable, timer_one_irq_enable}),
        .result(res)
    );

    // ----------------------------------------------------------------
    // timer request flags
    // ----------------------------------------------------------------
    logic [3:0] sw_flag_clr;
    logic timer_one_request_flag;
    logic timer_two_request_flag;
    logic timer_three_request_flag;
    logic timer_four_request_flag;

    assign sw_flag_clr = (wr_en && paddr == tfs_pkg::OFS_FLAGS) ? pwdata[3:0] : 4'h0;

    // skip clears its flag; a timer event in the same cycle still sets it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            request_flags_q <= tfs_pkg::FLAGS_RST;
        else
            request_flags_q <= (request_flags_q & ~res.clear & ~sw_flag_clr)
                               | timer_event;
    end

    assign timer_one_request_flag = request_flags_q[0];
    assign timer_two_request_flag = request_flags_q[1];
    assign timer_three_request_flag = request_flags_q[2];
    assign timer_four_request_flag = request_flags_q[3];

    // ----------------------------------------------------------------
    // sequencing outputs
    // ----------------------------------------------------------------
    // single-cycle completion; the carry flag is outside this block and untouched
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            instr_done_q <= 1'b0;
        else
            instr_done_q <= res.hit;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            skip_next_q <= 1'b0;
        else
            skip_next_q <= res.skip;
    end

    // ----------------------------------------------------------------
    // last result and skip counter
    // ----------------------------------------------------------------
    logic [4:0] last_q;
    logic [15:0] skip_cnt_q;

    // last: [4] skipped, [3] nop, [2] valid, [1:0] timer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            last_q <= 5'h00;
        else if (res.hit)
            last_q <= {res.skip, res.nop, 1'b1, res.timer};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            skip_cnt_q <= tfs_pkg::SKIP_CNT_RST;
        else if (wr_en && paddr == tfs_pkg::OFS_SKIP_CNT)
            skip_cnt_q <= pwdata[15:0];
        else if (res.skip)
            skip_cnt_q <= skip_cnt_q + 16'h0001;
    end

    // ----------------------------------------------------------------
    // interrupt status: [3:0] skip taken per timer, [7:4] nop per timer
    // ----------------------------------------------------------------
    logic [7:0] irq_events;
    logic [7:0] irq_clr;
    logic [7:0] irq_stat_q;
    logic [7:0] irq_mask_q;

    assign irq_events = {res.nop ? (4'h1 << res.timer) : 4'h0, res.clear};
    assign irq_clr = (wr_en && paddr == tfs_pkg::OFS_IRQ_STAT) ? pwdata[7:0] : 8'h00;

    tfs_irq_status #(.W(8)) u_irq
    (
        .pclk(pclk),
        .presetn(presetn),
        .events(irq_events),
        .clr(irq_clr),
        .mask_d(pwdata[7:0]),
        .mask_we(wr_en && paddr == tfs_pkg::OFS_IRQ_MASK),
        .stat_q(irq_stat_q),
        .mask_q(irq_mask_q),
        .irq(irq)
    );

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    logic [31:0] rdata_d;

    always_comb
    begin
        case (paddr)
            tfs_pkg::OFS_CTRL1: rdata_d = {28'h0, first_interrupt_control_register_q};
            tfs_pkg::OFS_CTRL2: rdata_d = {28'h0, second_interrupt_control_register_q};
            tfs_pkg::OFS_FLAGS: rdata_d = {28'h0, timer_four_request_flag,
                                           timer_three_request_flag,
                                           timer_two_request_flag,
                                           timer_one_request_flag};
            tfs_pkg::OFS_IRQ_STAT: rdata_d = {24'h0, irq_stat_q};
            tfs_pkg::OFS_IRQ_MASK: rdata_d = {24'h0, irq_mask_q};
            tfs_pkg::OFS_LAST: rdata_d = {27'h0, last_q};
            tfs_pkg::OFS_SKIP_CNT: rdata_d = {16'h0, skip_cnt_q};
            default: rdata_d = 32'h0;
        endcase
    end

    // prdata is a flop loaded in the setup cycle so it is valid in the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
            prdata <= rdata_d;
        else if (rd_en)
            prdata <= prdata;
        else
            prdata <= 32'h0;
    end

endmodule // tfs_top

// ===== tb/tfs_sva.sv
// assertions on the ports of the timer flag skip logic
`timescale 1ns/1ps
module tfs_sva
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // instruction side
    input wire logic instr_valid,
    input wire logic [9:0] instr_opcode,
    input wire logic [3:0] timer_event,
    input wire logic skip_next_q,
    input wire logic instr_done_q,
    input wire logic [3:0] request_flags_q
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    sequence s_hit;
        instr_valid && instr_opcode[9:2] == 8'ha0;
    endsequence
    // flag set and no new event racing it, so skip and clear must agree
    sequence s_go(int n);
        s_hit ##0 (instr_opcode[1:0] == n && request_flags_q[n] && !timer_event[n]);
    endsequence

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_t1;
        s_go(0) |=> skip_next_q != request_flags_q[0];
    endproperty
    property p_t2;
        s_go(1) |=> skip_next_q != request_flags_q[1];
    endproperty
    property p_t3;
        s_go(2) |=> skip_next_q != request_flags_q[2];
    endproperty
    property p_t4;
        s_go(3) |=> skip_next_q != request_flags_q[3];
    endproperty
    property p_done;
        s_hit |=> instr_done_q;
    endproperty
    property p_quiet;
        !(instr_valid && instr_opcode[9:2] == 8'ha0) |=> !instr_done_q && !skip_next_q;
    endproperty
    property p_zero;
        s_hit ##0 !request_flags_q[instr_opcode[1:0]] |=> !skip_next_q;
    endproperty
    property p_set;
        |timer_event |=> (request_flags_q & $past(timer_event)) == $past(timer_event);
    endproperty

    a_t1: assert property (p_t1) else $error("timer one skip and clear disagree");
    a_t2: assert property (p_t2) else $error("timer two skip and clear disagree");
    a_t3: assert property (p_t3) else $error("timer three skip and clear disagree");
    a_t4: assert property (p_t4) else $error("timer four skip and clear disagree");
    a_done: assert property (p_done) else $error("no done after skip opcode");
    a_quiet: assert property (p_quiet) else $error("done or skip without opcode");
    a_zero: assert property (p_zero) else $error("skip with clear flag");
    a_set: assert property (p_set) else $error("timer event did not set flag");
endmodule // tfs_sva

// ===== tb/tfs_top_bench.sv
// self-checking bench for the timer flag skip logic
`timescale 1ns/1ps
module tfs_top_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic instr_valid, skip_next_q, instr_done_q;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [9:0] instr_opcode;
    logic [3:0] timer_event, request_flags_q, en, fl;
    logic [1:0] t;
    logic sk;
    logic [15:0] cnt;
    logic q_sk[$];
    logic [32:0] q_rd[$];
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;

    tfs_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr_valid(instr_valid), .instr_opcode(instr_opcode),
        .timer_event(timer_event), .skip_next_q(skip_next_q), .instr_done_q(instr_done_q),
        .request_flags_q(request_flags_q), .irq(irq));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic [32:0] e, input logic [32:0] s);
        tests_run++;
        if (s !== e)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    task print_verdict;
        if (failures == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [32:0] e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) q_rd.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ins(input logic [1:0] n, input logic s);
        @(posedge pclk);
        instr_valid <= 1'b1;
        instr_opcode <= tfs_pkg::OP_SKIP_T1 + 10'(n);
        q_sk.push_back(s);
        cnt += 16'(s);
    endtask
    task idle;
        @(posedge pclk);
        instr_valid <= 1'b0;
        timer_event <= 4'h0;
    endtask
    task automatic ev(input logic [3:0] m);
        @(posedge pclk);
        timer_event <= m;
        idle();
    endtask
    task automatic mirq(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d, '0);
        @(negedge pclk);
        chk("irq", {32'h0, e}, {32'h0, irq});
    endtask

    // ----------------------------------------------------------------
    // clock, watcher and timeout
    // ----------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (presetn && instr_done_q === 1'b1)
            chk("skip_next_q", {32'h0, q_sk.size() ? q_sk.pop_front() : 1'bx},
                {32'h0, skip_next_q});
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk("prdata", q_rd.size() ? q_rd.pop_front() : 'x, {pslverr, prdata});
        // limit last, so nothing runs after the verdict
        if (cyc == 5000)
        begin
            failures++;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {instr_valid, instr_opcode, timer_event} = '0;
        r = 32'hcc9f3229;
        cnt = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // every register reads zero out of reset
        for (int a = 0; a < 28; a += 4) apb(1'b0, 8'(a), '0, '0);
        for (int i = 0; i < 24; i++)
        begin
            r = lfsr(r);
            en = r[3:0];
            fl = r[7:4];
            t = r[9:8];
            sk = fl[t] & ~en[t];
            apb(1'b1, tfs_pkg::OFS_CTRL1, {28'h0, en[1:0], 2'b00}, '0);
            apb(1'b1, tfs_pkg::OFS_CTRL2, {30'h0, en[3:2]}, '0);
            apb(1'b1, tfs_pkg::OFS_FLAGS, 32'hf, '0);
            ev(fl);
            ins(t, sk);
            idle();
            @(negedge pclk);
            chk("request_flags_q", {29'h0, fl & ~(4'(sk) << t)}, {29'h0, request_flags_q});
            apb(1'b0, tfs_pkg::OFS_FLAGS, '0, {29'h0, fl & ~(4'(sk) << t)});
        end
        apb(1'b1, tfs_pkg::OFS_IRQ_STAT, 32'hff, '0);
        apb(1'b1, tfs_pkg::OFS_CTRL1, '0, '0);
        apb(1'b1, tfs_pkg::OFS_CTRL2, '0, '0);
        mirq(tfs_pkg::OFS_IRQ_MASK, 32'h1, 1'b0);
        ev(4'h1);
        // back to back: the second sees the flag already cleared
        ins(2'd0, 1'b1);
        ins(2'd0, 1'b0);
        idle();
        @(negedge pclk);
        chk("irq", 33'h1, {32'h0, irq});
        mirq(tfs_pkg::OFS_IRQ_MASK, 32'h0, 1'b0);
        mirq(tfs_pkg::OFS_IRQ_MASK, 32'h1, 1'b1);
        mirq(tfs_pkg::OFS_IRQ_STAT, 32'h1, 1'b0);
        apb(1'b0, 8'h1c, '0, {1'b1, 32'h0});
        apb(1'b0, tfs_pkg::OFS_SKIP_CNT, '0, {17'h0, cnt});
        // foreign opcode with a flag set: no answer, flag kept
        ev(4'h2);
        @(posedge pclk);
        instr_valid <= 1'b1;
        instr_opcode <= tfs_pkg::OP_SKIP_T4 + 10'h001;
        idle();
        @(negedge pclk);
        chk("request_flags_q", 33'h1, {32'h0, request_flags_q[1]});
        // second reset in mid-run: every register back to zero
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 28; a += 4) apb(1'b0, 8'(a), '0, '0);
        @(negedge pclk);
        chk("irq", 33'h0, {32'h0, irq});
        repeat (4) @(posedge pclk);
        chk("queues", '0, 33'(q_sk.size() + q_rd.size()));
        print_verdict();
    end
endmodule // tfs_top_bench

bind tfs_top tfs_sva chk_u (.pclk(pclk), .presetn(presetn), .instr_valid(instr_valid),
    .instr_opcode(instr_opcode), .timer_event(timer_event), .skip_next_q(skip_next_q),
    .instr_done_q(instr_done_q), .request_flags_q(request_flags_q));
